// file: rtl/cptmr_pkg.sv
// package with the constants shared by the per-core timer block
package cptmr_pkg;
	localparam int NCORE = 2;
	localparam int CNT_W = 32;
	localparam int PRE_W = 8;
	localparam int GLB_W = 64;
	localparam int SEL_W = 3;
	// control word fields for the interval timer and the watchdog
	localparam int CTL_EN_BIT = 0;
	localparam int CTL_AUTO_BIT = 1;
	localparam int CTL_IRQ_BIT = 2;
	localparam int CTL_WDOG_BIT = 3;
	localparam int CTL_PRE_LSB = 8;
	localparam int CTL_PRE_MSB = 15;
	// clear mask fields
	localparam int CLR_TMR_BIT = 0;
	localparam int CLR_WD_BIT = 1;
	localparam int CLR_CMP_BIT = 2;
	localparam int CMP_EN_BIT = 0;
	localparam int CMP_IRQ_BIT = 1;
	localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
	localparam logic [GLB_W-1:0] GLB_RST = 64'h0000_0000_0000_0000;
	localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
	localparam logic [GLB_W-1:0] GLB_ONE = 64'h0000_0000_0000_0001;
	localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
	// items that a command may write
	typedef enum logic [SEL_W-1:0] {
		SEL_TMR_LOAD = 3'h0,
		SEL_TMR_CTRL = 3'h1,
		SEL_WD_LOAD = 3'h2,
		SEL_WD_CTRL = 3'h3,
		SEL_CMP_LO = 3'h4,
		SEL_CMP_HI = 3'h5,
		SEL_CMP_CTRL = 3'h6,
		SEL_CLEAR = 3'h7
	} cptmr_sel_type;
endpackage

// file: rtl/cptmr_down_counter.sv
// prescaled 32-bit down counter with single-shot and auto-reload operation
`timescale 1ns/1ps
module cptmr_down_counter (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic load_i,
	input wire logic [cptmr_pkg::CNT_W-1:0] load_val_i,
	input wire logic enable_i,
	input wire logic auto_i,
	input wire logic [cptmr_pkg::PRE_W-1:0] prescale_i,
	output logic expire_o,
	output logic [cptmr_pkg::CNT_W-1:0] count_o
);
	logic [cptmr_pkg::PRE_W-1:0] pre_r;
	logic [cptmr_pkg::CNT_W-1:0] count_r;
	logic [cptmr_pkg::CNT_W-1:0] reload_r;
	logic stopped_r;
	logic expire_r;
	logic step;
	logic hit;

	// one counter step every prescale+1 clocks while running
	assign step = enable_i && !stopped_r && !load_i && (pre_r == prescale_i);
	assign hit = step && (count_r <= cptmr_pkg::CNT_ONE);

	// prescaler divides the input clock
	always_ff @(posedge clock_i) begin
		if (reset_i || load_i || !enable_i || step) begin
			pre_r <= cptmr_pkg::PRE_RST;
		end else if (!stopped_r) begin
			pre_r <= pre_r + cptmr_pkg::PRE_ONE;
		end
	end

	// counter counts down, expiry is the step taken from a count of one or zero, which reloads in auto mode and clears otherwise
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			count_r <= cptmr_pkg::CNT_RST;
			reload_r <= cptmr_pkg::CNT_RST;
		end else if (load_i) begin
			count_r <= load_val_i;
			reload_r <= load_val_i;
		end else if (hit) begin
			count_r <= auto_i ? reload_r : cptmr_pkg::CNT_RST;
		end else if (step) begin
			count_r <= count_r - cptmr_pkg::CNT_ONE;
		end
	end

	// single-shot stops after one expiry until the next load
	always_ff @(posedge clock_i) begin
		if (reset_i || load_i) begin
			stopped_r <= 1'b0;
		end else if (hit && !auto_i) begin
			stopped_r <= 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			expire_r <= 1'b0;
		end else begin
			expire_r <= hit;
		end
	end

	assign expire_o = expire_r;
	assign count_o = count_r;
endmodule

// file: rtl/cptmr_top.sv
// per-core interval timers, watchdogs and the shared global timer with compares
`timescale 1ns/1ps
module cptmr_top (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_src_i,
	input wire logic cmd_dst_i,
	input wire logic [cptmr_pkg::SEL_W-1:0] cmd_sel_i,
	input wire logic [cptmr_pkg::CNT_W-1:0] cmd_data_i,
	output logic cmd_refused_o,
	output logic [cptmr_pkg::NCORE-1:0] timer_irq_o,
	output logic [cptmr_pkg::NCORE-1:0] wdog_irq_o,
	output logic [cptmr_pkg::NCORE-1:0] cmp_irq_o,
	output logic [cptmr_pkg::NCORE-1:0] core_reset_o,
	output logic [cptmr_pkg::NCORE-1:0] timer_flag_o,
	output logic [cptmr_pkg::NCORE-1:0] wdog_flag_o,
	output logic [cptmr_pkg::NCORE-1:0] cmp_flag_o,
	output logic [cptmr_pkg::NCORE-1:0][cptmr_pkg::CNT_W-1:0] timer_count_o,
	output logic [cptmr_pkg::NCORE-1:0][cptmr_pkg::CNT_W-1:0] wdog_count_o,
	output logic [cptmr_pkg::GLB_W-1:0] global_count_o
);
	// ****************************************
	// command acceptance and global counter
	// ****************************************
	logic accept;
	logic refused_r;
	logic [cptmr_pkg::GLB_W-1:0] global_r;

	// a core may touch only its own private set
	assign accept = cmd_valid_i && (cmd_src_i == cmd_dst_i);

	// refused accesses are reported for one cycle
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			refused_r <= 1'b0;
		end else begin
			refused_r <= cmd_valid_i && (cmd_src_i != cmd_dst_i);
		end
	end

	// shared global counter steps on every clock
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			global_r <= cptmr_pkg::GLB_RST;
		end else begin
			global_r <= global_r + cptmr_pkg::GLB_ONE;
		end
	end

	assign cmd_refused_o = refused_r;
	assign global_count_o = global_r;

	// ****************************************
	// per-core private timers
	// ****************************************
	genvar c;
	generate
		for (c = 0; c < cptmr_pkg::NCORE; c++) begin : g_core
			logic mine;
			logic [cptmr_pkg::CNT_W-1:0] tctl_r;
			logic [cptmr_pkg::CNT_W-1:0] wctl_r;
			logic [cptmr_pkg::GLB_W-1:0] cmp_r;
			logic [1:0] cctl_r;
			logic tmr_flag_r;
			logic wd_flag_r;
			logic cmp_flag_r;
			logic rst_req_r;
			logic tmr_exp;
			logic wd_exp;
			logic cmp_hit;
			logic tmr_load;
			logic wd_load;
			logic do_clear;

			assign mine = accept && (cmd_dst_i == 1'(c));
			assign tmr_load = mine && (cmd_sel_i == cptmr_pkg::SEL_TMR_LOAD);
			assign wd_load = mine && (cmd_sel_i == cptmr_pkg::SEL_WD_LOAD);
			assign do_clear = mine && (cmd_sel_i == cptmr_pkg::SEL_CLEAR);

			// ****************************************
			// control words written by the owning core
			// ****************************************

			// interval timer control word
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					tctl_r <= cptmr_pkg::CNT_RST;
				end else if (mine && (cmd_sel_i == cptmr_pkg::SEL_TMR_CTRL)) begin
					tctl_r <= cmd_data_i;
				end
			end

			// watchdog control word, one bit picks watchdog or second timer
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					wctl_r <= cptmr_pkg::CNT_RST;
				end else if (mine && (cmd_sel_i == cptmr_pkg::SEL_WD_CTRL)) begin
					wctl_r <= cmd_data_i;
				end
			end

			// compare value, each half written on its own and live at once
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					cmp_r <= cptmr_pkg::GLB_RST;
				end else if (mine && (cmd_sel_i == cptmr_pkg::SEL_CMP_LO)) begin
					cmp_r[cptmr_pkg::CNT_W-1:0] <= cmd_data_i;
				end else if (mine && (cmd_sel_i == cptmr_pkg::SEL_CMP_HI)) begin
					cmp_r[cptmr_pkg::GLB_W-1:cptmr_pkg::CNT_W] <= cmd_data_i;
				end
			end

			// compare control: match enable and interrupt enable
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					cctl_r <= 2'h0;
				end else if (mine && (cmd_sel_i == cptmr_pkg::SEL_CMP_CTRL)) begin
					cctl_r <= cmd_data_i[cptmr_pkg::CMP_IRQ_BIT:cptmr_pkg::CMP_EN_BIT];
				end
			end

			// ****************************************
			// interval timer and watchdog counters
			// ****************************************

			// interval timer
			cptmr_down_counter u_tmr (
				.clock_i(clock_i),
				.reset_i(reset_i),
				.load_i(tmr_load),
				.load_val_i(cmd_data_i),
				.enable_i(tctl_r[cptmr_pkg::CTL_EN_BIT]),
				.auto_i(tctl_r[cptmr_pkg::CTL_AUTO_BIT]),
				.prescale_i(tctl_r[cptmr_pkg::CTL_PRE_MSB:cptmr_pkg::CTL_PRE_LSB]),
				.expire_o(tmr_exp),
				.count_o(timer_count_o[c])
			);

			// watchdog, reloaded by software writes of its load value
			cptmr_down_counter u_wd (
				.clock_i(clock_i),
				.reset_i(reset_i),
				.load_i(wd_load),
				.load_val_i(cmd_data_i),
				.enable_i(wctl_r[cptmr_pkg::CTL_EN_BIT]),
				.auto_i(wctl_r[cptmr_pkg::CTL_AUTO_BIT]),
				.prescale_i(wctl_r[cptmr_pkg::CTL_PRE_MSB:cptmr_pkg::CTL_PRE_LSB]),
				.expire_o(wd_exp),
				.count_o(wdog_count_o[c])
			);

			// compare hit when the global counter reaches the value
			assign cmp_hit = cctl_r[cptmr_pkg::CMP_EN_BIT] && (global_r == cmp_r);

			// ****************************************
			// sticky event flags and reset request
			// ****************************************

			// interval timer flag, a set in the clear cycle wins
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					tmr_flag_r <= 1'b0;
				end else begin
					tmr_flag_r <= tmr_exp || (tmr_flag_r && !(do_clear && cmd_data_i[cptmr_pkg::CLR_TMR_BIT]));
				end
			end

			// watchdog flag, a set in the clear cycle wins
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					wd_flag_r <= 1'b0;
				end else begin
					wd_flag_r <= wd_exp || (wd_flag_r && !(do_clear && cmd_data_i[cptmr_pkg::CLR_WD_BIT]));
				end
			end

			// compare flag, a set in the clear cycle wins
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					cmp_flag_r <= 1'b0;
				end else begin
					cmp_flag_r <= cmp_hit || (cmp_flag_r && !(do_clear && cmd_data_i[cptmr_pkg::CLR_CMP_BIT]));
				end
			end

			// reset request held until the block is reset
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					rst_req_r <= 1'b0;
				end else if (wd_exp && wctl_r[cptmr_pkg::CTL_WDOG_BIT]) begin
					rst_req_r <= 1'b1;
				end
			end

			// ****************************************
			// per-core outputs
			// ****************************************

			// interrupts follow flags when enabled, the watchdog one only while its watchdog bit is clear
			assign timer_irq_o[c] = tmr_flag_r && tctl_r[cptmr_pkg::CTL_IRQ_BIT];
			assign wdog_irq_o[c] = wd_flag_r && wctl_r[cptmr_pkg::CTL_IRQ_BIT] && !wctl_r[cptmr_pkg::CTL_WDOG_BIT];
			assign cmp_irq_o[c] = cmp_flag_r && cctl_r[cptmr_pkg::CMP_IRQ_BIT];
			assign core_reset_o[c] = rst_req_r;
			assign timer_flag_o[c] = tmr_flag_r;
			assign wdog_flag_o[c] = wd_flag_r;
			assign cmp_flag_o[c] = cmp_flag_r;
		end
	endgenerate
endmodule

// file: dv/cptmr_sva.sv
// port assertions for the per-core timer block
`timescale 1ns/1ps
module cptmr_sva (
	input logic clock_i,
	input logic reset_i,
	input logic cmd_valid_i,
	input logic cmd_src_i,
	input logic cmd_dst_i,
	input logic [2:0] cmd_sel_i,
	input logic [31:0] cmd_data_i,
	input logic cmd_refused_o,
	input logic [1:0] timer_irq_o,
	input logic [1:0] wdog_irq_o,
	input logic [1:0] cmp_irq_o,
	input logic [1:0] core_reset_o,
	input logic [1:0] timer_flag_o,
	input logic [1:0] wdog_flag_o,
	input logic [1:0] cmp_flag_o,
	input logic [1:0][31:0] timer_count_o,
	input logic [63:0] global_count_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// a command that core 0 makes to its own set
	wire own0 = cmd_valid_i && !cmd_src_i && !cmd_dst_i;
	property p_refuse; !$past(reset_i) |-> cmd_refused_o == $past(cmd_valid_i && cmd_src_i != cmd_dst_i); endproperty
	a_refuse: assert property (p_refuse) else $error("refusal pulse wrong");
	property p_glb; !$past(reset_i) |-> global_count_o == $past(global_count_o) + 64'h1; endproperty
	a_glb: assert property (p_glb) else $error("global count step wrong");
	property p_tirq; (timer_irq_o & ~timer_flag_o) == 2'h0; endproperty
	a_tirq: assert property (p_tirq) else $error("timer irq without flag");
	property p_wirq; (wdog_irq_o & ~wdog_flag_o) == 2'h0; endproperty
	a_wirq: assert property (p_wirq) else $error("second timer irq without flag");
	property p_cirq; (cmp_irq_o & ~cmp_flag_o) == 2'h0; endproperty
	a_cirq: assert property (p_cirq) else $error("compare irq without flag");
	property p_rst; !$past(reset_i) |-> (core_reset_o & $past(core_reset_o)) == $past(core_reset_o); endproperty
	a_rst: assert property (p_rst) else $error("core reset request dropped");
	property p_flag; $fell(timer_flag_o[0]) |-> $past(own0 && cmd_sel_i == cptmr_pkg::SEL_CLEAR && cmd_data_i[0]); endproperty
	a_flag: assert property (p_flag) else $error("timer flag dropped uncleared");
	property p_tcnt; !$past(reset_i) && timer_count_o[0] > $past(timer_count_o[0]) |->
		$past(timer_count_o[0]) <= 32'h1 || $past(own0 && cmd_sel_i == cptmr_pkg::SEL_TMR_LOAD); endproperty
	a_tcnt: assert property (p_tcnt) else $error("timer count rose unexpectedly");
endmodule

// file: dv/cptmr_core_model.sv
// model of the cores that write timer commands
`timescale 1ns/1ps
module cptmr_core_model (
	input logic clock_i,
	output logic cmd_valid_o,
	output logic cmd_src_o,
	output logic cmd_dst_o,
	output logic [cptmr_pkg::SEL_W-1:0] cmd_sel_o,
	output logic [cptmr_pkg::CNT_W-1:0] cmd_data_o
);
	// idle until the first write
	initial begin
		cmd_valid_o = 1'b0;
		cmd_src_o = 1'b0;
		cmd_dst_o = 1'b0;
		cmd_sel_o = 3'h0;
		cmd_data_o = 32'h0;
	end
	// one-cycle write pulse; data is scrambled once released
	task automatic wr(input logic s, input logic d, input logic [2:0] k, input logic [31:0] v);
		@(negedge clock_i);
		cmd_valid_o = 1'b1;
		cmd_src_o = s;
		cmd_dst_o = d;
		cmd_sel_o = k;
		cmd_data_o = v;
		@(negedge clock_i);
		cmd_valid_o = 1'b0;
		cmd_data_o = ~v;
	endtask
endmodule

// file: dv/cptmr_top_tb.sv
// self-checking bench for the per-core timer block
`timescale 1ns/1ps
module cptmr_top_tb;
	logic clock_i, reset_i, cmd_valid_i, cmd_src_i, cmd_dst_i, cmd_refused_o;
	logic [2:0] cmd_sel_i;
	logic [31:0] cmd_data_i;
	logic [1:0] timer_irq_o, wdog_irq_o, cmp_irq_o, core_reset_o, timer_flag_o, wdog_flag_o, cmp_flag_o;
	logic [1:0][31:0] timer_count_o, wdog_count_o;
	logic [63:0] global_count_o;
	int n_fail = 0;
	int checks = 0;
	cptmr_top cptmr_top_inst (.clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_src_i(cmd_src_i),
		.cmd_dst_i(cmd_dst_i), .cmd_sel_i(cmd_sel_i), .cmd_data_i(cmd_data_i), .cmd_refused_o(cmd_refused_o),
		.timer_irq_o(timer_irq_o), .wdog_irq_o(wdog_irq_o), .cmp_irq_o(cmp_irq_o), .core_reset_o(core_reset_o),
		.timer_flag_o(timer_flag_o), .wdog_flag_o(wdog_flag_o), .cmp_flag_o(cmp_flag_o),
		.timer_count_o(timer_count_o), .wdog_count_o(wdog_count_o), .global_count_o(global_count_o));
	cptmr_core_model cptmr_core_model_inst (.clock_i(clock_i), .cmd_valid_o(cmd_valid_i), .cmd_src_o(cmd_src_i),
		.cmd_dst_o(cmd_dst_i), .cmd_sel_o(cmd_sel_i), .cmd_data_o(cmd_data_i));
	// 125 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic w(input logic s, input logic d, input logic [2:0] k, input logic [31:0] v);
		cptmr_core_model_inst.wr(s, d, k, v);
	endtask
	task automatic give_verdict();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// core 0 single shot, prescale 1, irq on; core 1 auto reload, irq off
	task automatic t_timer();
		int n;
		w(0, 0, cptmr_pkg::SEL_TMR_CTRL, 32'h0105);
		w(0, 0, cptmr_pkg::SEL_TMR_LOAD, 32'h3);
		chk("tload", timer_count_o[0], 3);
		for (n = 0; n < 60 && timer_flag_o[0] !== 1'b1; n++) @(negedge clock_i);
		chk("tlat", n inside {[6:10]}, 1);
		chk("tirq", timer_irq_o[0], 1);
		repeat (6) @(negedge clock_i);
		chk("tstop", timer_count_o[0], 0);
		w(0, 0, cptmr_pkg::SEL_CLEAR, 32'h1);
		chk("tclr", {timer_flag_o[0], timer_irq_o[0]}, 0);
		w(1, 1, cptmr_pkg::SEL_TMR_LOAD, 32'h2);
		w(1, 1, cptmr_pkg::SEL_TMR_CTRL, 32'h0003);
		for (n = 0; n < 60 && timer_flag_o[1] !== 1'b1; n++) @(negedge clock_i);
		chk("tmask", {timer_flag_o[1], timer_irq_o[1]}, 2'h2);
		repeat (5) @(negedge clock_i);
		chk("treload", timer_count_o[1] != 0, 1);
	endtask
	// core 1 writes core 0's timer and is turned away
	task automatic t_refuse();
		w(1, 0, cptmr_pkg::SEL_TMR_LOAD, 32'h77);
		chk("refused", cmd_refused_o, 1);
		@(negedge clock_i);
		chk("unchanged", timer_count_o[0], 0);
		chk("refpulse", cmd_refused_o, 0);
	endtask
	// core 0 watchdog mode with kicks, then starved; core 1 as second timer
	task automatic t_wdog();
		int n;
		w(0, 0, cptmr_pkg::SEL_WD_LOAD, 32'h6);
		w(0, 0, cptmr_pkg::SEL_WD_CTRL, 32'h000d);
		repeat (3) w(0, 0, cptmr_pkg::SEL_WD_LOAD, 32'h6);
		chk("kicked", core_reset_o, 0);
		chk("wkick", wdog_count_o[0], 32'h6);
		for (n = 0; n < 60 && core_reset_o[0] !== 1'b1; n++) @(negedge clock_i);
		chk("wreset", {core_reset_o, wdog_irq_o[0], wdog_flag_o[0]}, 4'h5);
		w(1, 1, cptmr_pkg::SEL_WD_LOAD, 32'h2);
		w(1, 1, cptmr_pkg::SEL_WD_CTRL, 32'h0005);
		for (n = 0; n < 60 && wdog_flag_o[1] !== 1'b1; n++) @(negedge clock_i);
		chk("w2tmr", {core_reset_o[1], wdog_irq_o[1]}, 1);
	endtask
	// global count steps and core 0 compare match
	task automatic t_glb();
		int n;
		logic [63:0] g;
		g = global_count_o;
		repeat (10) @(negedge clock_i);
		chk("gstep", global_count_o, g + 64'ha);
		g = global_count_o + 64'h28;
		w(0, 0, cptmr_pkg::SEL_CMP_LO, g[31:0]);
		w(0, 0, cptmr_pkg::SEL_CMP_HI, g[63:32]);
		w(0, 0, cptmr_pkg::SEL_CMP_CTRL, 32'h3);
		for (n = 0; n < 99 && cmp_flag_o[0] !== 1'b1; n++) @(negedge clock_i);
		chk("cmatch", global_count_o - g, 1);
		chk("cirq", {cmp_irq_o, cmp_flag_o[1]}, 3'h2);
	endtask
	// mid-run reset clears the sticky request, the flags and the global count
	task automatic t_reset();
		reset_i = 1'b1;
		repeat (2) @(negedge clock_i);
		reset_i = 1'b0;
		chk("rstreq", core_reset_o, 0);
		chk("rstglb", global_count_o, 0);
		chk("rstflag", {timer_flag_o, wdog_flag_o, cmp_flag_o}, 0);
		@(negedge clock_i);
		chk("rstrun", global_count_o, 1);
	endtask
	initial begin
		reset_i = 1'b1;
		repeat (20) @(negedge clock_i);
		reset_i = 1'b0;
		t_timer();
		t_refuse();
		t_wdog();
		t_glb();
		t_reset();
		give_verdict();
	end
	// hang guard, almost forty times the expected run
	initial begin
		#40000;
		n_fail++;
		give_verdict();
	end
endmodule
bind cptmr_top cptmr_sva cptmr_sva_inst (.clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
	.cmd_src_i(cmd_src_i), .cmd_dst_i(cmd_dst_i), .cmd_sel_i(cmd_sel_i), .cmd_data_i(cmd_data_i),
	.cmd_refused_o(cmd_refused_o), .timer_irq_o(timer_irq_o), .wdog_irq_o(wdog_irq_o), .cmp_irq_o(cmp_irq_o),
	.core_reset_o(core_reset_o), .timer_flag_o(timer_flag_o), .wdog_flag_o(wdog_flag_o), .cmp_flag_o(cmp_flag_o),
	.timer_count_o(timer_count_o), .global_count_o(global_count_o));
